// ---- indexer_pkg.sv ----
package indexer_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] ctrl_offset = 8'h00;
    localparam logic [7:0] param_offset = 8'h04;
    localparam logic [7:0] limit_offset = 8'h08;
    localparam logic [7:0] delay_offset = 8'h0C;
    localparam logic [7:0] status_offset = 8'h10;
    localparam logic [7:0] position_offset = 8'h14;

    // Control register field positions.
    localparam int ctrl_start_pos = 0;
    localparam int ctrl_dir_pos = 1;
    localparam int ctrl_mode_a_pos = 2;
    localparam int ctrl_mode_b_pos = 3;
    localparam int ctrl_method_pos = 4;
    localparam int ctrl_homed_pos = 5;
    localparam int ctrl_settled_pos = 6;

    // Parameter register field positions.
    localparam int param_mode_pos = 0;
    localparam int param_count_pos = 8;
    localparam int param_assign_pos = 16;
    localparam int param_source_pos = 20;

    // Limit register field positions.
    localparam int limit_fwd_pos = 0;
    localparam int limit_rev_pos = 16;

    // Reset values.
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam logic [31:0] param_reset = 32'h0000_0800;
    localparam logic [31:0] limit_reset = 32'h0000_0000;
    localparam logic [31:0] delay_reset = 32'h0000_0000;

    // Control mode value that enables indexer positioning.
    localparam logic [3:0] indexer_mode_value = 4'h8;
    // Speed-source value meaning point-table speed.
    localparam logic [3:0] speed_src_table = 4'h0;
    // Largest station count.
    localparam int max_stations = 255;
    // Travel time per station step, as a stand-in for the motor.
    localparam int step_ns = 20;
    localparam int clk_ns = 5;
    localparam int step_cycles = (step_ns + clk_ns - 1) / clk_ns;

    // Response codes on the bus.
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    typedef struct packed {
        logic start_request_bit;
        logic direction_select_bit;
        logic opmode_select_a;
        logic opmode_select_b;
        logic method_select_bit;
    } link_bits_type;

    typedef struct packed {
        logic [15:0] station_select_word;
        logic [15:0] speed_table_select_word;
        logic [15:0] next_station_word;
        logic [15:0] speed_cmd_low_word;
    } link_words_type;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_move = 2'b01,
        st_hold = 2'b11
    } seq_state_type;

endpackage

// ---- indexer_station_positioning.sv ----
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: Controller sets control mode parameter to 8 before any station command.
// R2: Mode bit A off and B on selects fixed-direction indexer positioning.
// R3: Direction bit off moves toward lower stations, on toward higher.
// R4: Station numbering direction around the circle comes from a parameter.
// R5: One revolution is divided into a set count of stations, at most 255.
// R6: Station zero is the home position.
// R7: Start rise positions to the selected station with the selected table.
// R8: Start before homing raises the homing warning and is ignored.
// R9: Start is ignored while a positioning is in progress.
// R10: Controller waits for travel complete before the next start.
// R11: Speed table is latched only at start; later changes do nothing.
// R12: Controller updates station and speed words ahead of start.
// R13: Controller waits 8 ms plus link delay after mode select.
// R14: Torque limit switches to running limit at start, back after delay.
// R15: Stop-limit delay counts from in-position turning on.
// R16: After power-on, in-position is set if droop is within range.
// R17: Method bit on with table speed source takes station from next word.
// R18: Position/speed variant takes table number from low speed word.
module indexer_station_positioning #(
    parameter int station_width = 8,
    parameter int delay_width = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire indexer_pkg::link_words_type link_words,
    output logic travel_complete_flag,
    output logic in_position_flag,
    output logic homing_incomplete_warning,
    output logic [15:0] torque_limit,
    output logic [15:0] table_select,
    output logic [7:0] target_station
);
    import indexer_pkg::*;

    // Refuse widths that the station and delay fields cannot carry.
    localparam bit width_bad = (station_width != 8) || (delay_width < 1)
                               || (delay_width > 16);
    if (width_bad) begin : g_width_check
        $error("indexer_station_positioning: unsupported widths");
    end

    // Software-visible registers.
    logic [31:0] ctrl_q, param_q, limit_q, delay_q;
    logic aw_got_q, w_got_q;
    logic awready_q, wready_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q, rvalid_q, arready_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q, bresp_q;

    // Sequencer state.
    seq_state_type state_q, state_d;
    logic start_prev_q;
    logic [7:0] pos_q, target_q;
    logic [15:0] table_q;
    logic [31:0] step_cnt_q;
    logic [delay_width-1:0] hold_cnt_q;
    logic running_q;
    logic warn_q, inpos_q, done_q;
    logic [15:0] torque_q;

    // Control fields decoded from the registers.
    link_bits_type bits;
    wire [3:0] mode_param = param_q[param_mode_pos +: 4];
    wire [7:0] count_param = param_q[param_count_pos +: 8];
    wire assign_param = param_q[param_assign_pos];
    wire [3:0] source_param = param_q[param_source_pos +: 4];
    wire [15:0] fwd_limit = limit_q[limit_fwd_pos +: 16];
    wire [15:0] rev_limit = limit_q[limit_rev_pos +: 16];
    wire [15:0] stop_limit = delay_q[31:16];
    wire [delay_width-1:0] hold_delay = delay_q[delay_width-1:0];
    wire homed = ctrl_q[ctrl_homed_pos];
    wire droop_ok = ctrl_q[ctrl_settled_pos];

    // The link bits are held in the control register in this block.
    assign bits.start_request_bit = ctrl_q[ctrl_start_pos];
    assign bits.direction_select_bit = ctrl_q[ctrl_dir_pos];
    assign bits.opmode_select_a = ctrl_q[ctrl_mode_a_pos];
    assign bits.opmode_select_b = ctrl_q[ctrl_mode_b_pos];
    assign bits.method_select_bit = ctrl_q[ctrl_method_pos];

    // Indexer enable and variant selection.
    wire mode_ok = (mode_param == indexer_mode_value); // [R1]
    wire fixed_dir = !bits.opmode_select_a && bits.opmode_select_b; // [R2]
    wire pos_speed = bits.method_select_bit
                     && (source_param == speed_src_table); // [R17]
    wire start_rise = bits.start_request_bit && !start_prev_q;
    wire variant_ok = mode_ok && fixed_dir
                      && (!bits.method_select_bit || pos_speed);
    // Station from the selection word or from the next-station word.
    wire [7:0] sel_station = pos_speed
        ? link_words.next_station_word[7:0]
        : link_words.station_select_word[7:0]; // [R17]
    // Speed table from the table word or the low speed word.
    wire [15:0] sel_table = pos_speed
        ? link_words.speed_cmd_low_word
        : link_words.speed_table_select_word; // [R18]
    // Stations at or beyond the configured count are never started.
    wire station_ok = (count_param != 8'h00) && (sel_station < count_param);
    wire accept = start_rise && variant_ok && homed && station_ok
                  && (state_q == st_idle); // [R8] [R9]
    // Logical travel direction, mirrored when numbering is reversed.
    wire step_up = bits.direction_select_bit ^ assign_param; // [R3] [R4]
    wire [7:0] last_station = count_param - 8'h01;
    wire [7:0] pos_next = bits.direction_select_bit
        ? ((pos_q == last_station) ? 8'h00 : pos_q + 8'h01)
        : ((pos_q == 8'h00) ? last_station : pos_q - 8'h01); // [R3] [R5]
    // Arrival, step pacing and hold end for the stand-in motor.
    wire arrived = (pos_q == target_q);
    wire step_due = (step_cnt_q == 32'(step_cycles - 1));
    wire hold_done = (hold_cnt_q >= hold_delay);

    // Sequencer next state.
    always_comb begin
        state_d = state_q;
        case (state_q)
            st_idle: begin
                if (accept && sel_station != pos_q) begin
                    state_d = st_move;
                end else if (accept) begin
                    state_d = st_hold;
                end
            end
            st_move: begin
                if (arrived) begin
                    state_d = st_hold;
                end
            end
            st_hold: begin
                if (hold_done) begin
                    state_d = st_idle;
                end
            end
            default: state_d = st_idle;
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= st_idle;
            start_prev_q <= 1'b0;
            pos_q <= 8'h00; // [R6]
            target_q <= 8'h00;
            table_q <= 16'h0000;
            step_cnt_q <= 32'h0000_0000;
            hold_cnt_q <= '0;
            running_q <= 1'b0;
        end else begin
            state_q <= state_d;
            start_prev_q <= bits.start_request_bit;
            if (accept) begin
                target_q <= sel_station; // [R7]
                table_q <= sel_table; // [R11]
                running_q <= 1'b1;
            end else if (state_q == st_hold && hold_done) begin
                running_q <= 1'b0;
            end
            if (state_q == st_move && !arrived) begin
                step_cnt_q <= step_due ? 32'h0000_0000 : step_cnt_q + 32'h1;
                if (step_due) begin
                    pos_q <= pos_next;
                end
            end else begin
                step_cnt_q <= 32'h0000_0000;
            end
            if (state_q == st_hold && !hold_done) begin
                hold_cnt_q <= hold_cnt_q + 1'b1; // [R15]
            end else if (state_q != st_hold) begin
                hold_cnt_q <= '0;
            end
        end
    end

    // Flags and torque limit selection.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            warn_q <= 1'b0;
            inpos_q <= 1'b0;
            done_q <= 1'b0;
            torque_q <= 16'h0000;
        end else begin
            if (start_rise && variant_ok && !homed) begin
                warn_q <= 1'b1; // [R8]
            end else if (homed) begin
                warn_q <= 1'b0;
            end
            if (state_q == st_idle && !running_q) begin
                inpos_q <= droop_ok; // [R16]
            end else begin
                inpos_q <= (state_d == st_hold) || (state_q == st_hold);
            end
            done_q <= (state_d != st_move) && !accept;
            if (accept) begin
                torque_q <= step_up ? fwd_limit : rev_limit; // [R14]
            end else if (state_q == st_hold && hold_done) begin
                torque_q <= stop_limit; // [R14] [R15]
            end else if (!running_q) begin
                torque_q <= stop_limit;
            end
        end
    end

    // Write channel: address and data taken in either order.
    wire wr_go = aw_got_q && w_got_q && !bvalid_q;
    wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                         {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    // Byte-lane merge: unselected lanes keep their old value.
    wire [31:0] wkeep = ~wmask;
    wire [31:0] wnew = wdata_q & wmask;
    wire wr_hit = (awaddr_q == ctrl_offset) || (awaddr_q == param_offset)
                  || (awaddr_q == limit_offset) || (awaddr_q == delay_offset);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= resp_okay;
            ctrl_q <= ctrl_reset;
            param_q <= param_reset;
            limit_q <= limit_reset;
            delay_q <= delay_reset;
        end else begin
            if (s_axi_awvalid && !aw_got_q) begin
                aw_got_q <= 1'b1;
                awready_q <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_got_q) begin
                w_got_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? resp_okay : resp_slverr;
                case (awaddr_q)
                    ctrl_offset: ctrl_q <= (ctrl_q & wkeep) | wnew;
                    param_offset: param_q <= (param_q & wkeep) | wnew;
                    limit_offset: limit_q <= (limit_q & wkeep) | wnew;
                    delay_offset: delay_q <= (delay_q & wkeep) | wnew;
                    default: ctrl_q <= ctrl_q;
                endcase
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read channel with status and position views.
    wire [31:0] status_word = {26'h0, state_q, running_q, warn_q,
                               inpos_q, done_q};
    wire [31:0] position_word = {target_q, table_q[7:0], 8'h00, pos_q};
    // Read data selection; unmapped offsets answer with an error code.
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            ctrl_offset: rd_mux = ctrl_q;
            param_offset: rd_mux = param_q;
            limit_offset: rd_mux = limit_q;
            delay_offset: rd_mux = delay_q;
            status_offset: rd_mux = status_word;
            position_offset: rd_mux = position_word;
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Address is taken the cycle after it is offered; one read at a time.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= resp_okay;
        end else begin
            arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
            if (s_axi_arvalid && arready_q) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_hit ? resp_okay : resp_slverr;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Every output comes straight from a register.
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign travel_complete_flag = done_q;
    assign in_position_flag = inpos_q;
    assign homing_incomplete_warning = warn_q;
    assign torque_limit = torque_q;
    assign table_select = table_q;
    assign target_station = target_q;

endmodule
`default_nettype wire

// ---- indexer_station_positioning_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// Watches the bus handshakes and the sequencer outputs of the block.
module indexer_station_positioning_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic travel_complete_flag,
    input wire logic in_position_flag,
    input wire logic homing_incomplete_warning,
    input wire logic [15:0] torque_limit,
    input wire logic [15:0] table_select,
    input wire logic [7:0] target_station
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Both write halves taken together, and two cycles of travel in a row.
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_moving2;
        !travel_complete_flag ##1 !travel_complete_flag;
    endsequence
    property p_wr_answer;
        s_wr_taken |-> ##[1:4] s_axi_bvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_bresp_code;
        s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2;
    endproperty
    property p_frozen;
        s_moving2 |-> $stable(target_station) && $stable(table_select);
    endproperty
    property p_warn_idle;
        $rose(homing_incomplete_warning) |-> travel_complete_flag;
    endproperty
    property p_hold_torque;
        $rose(in_position_flag) |-> travel_complete_flag && $stable(torque_limit);
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write response missing");
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped early");
    a_rd_answer: assert property (p_rd_answer)
        else $error("read data late");
    a_bresp_code: assert property (p_bresp_code)
        else $error("bad write response code");
    a_frozen: assert property (p_frozen)
        else $error("target or table changed during travel");
    a_warn_idle: assert property (p_warn_idle)
        else $error("warning raised while travelling");
    a_hold_torque: assert property (p_hold_torque)
        else $error("torque changed as in-position rose");
endmodule

bind indexer_station_positioning indexer_station_positioning_asserts i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .travel_complete_flag(travel_complete_flag),
    .in_position_flag(in_position_flag),
    .homing_incomplete_warning(homing_incomplete_warning),
    .torque_limit(torque_limit), .table_select(table_select),
    .target_station(target_station));
`default_nettype wire

// ---- link_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Controller side of the cyclic link; words change only when loaded.
module link_master_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire indexer_pkg::link_words_type next_words,
    output var indexer_pkg::link_words_type link_words
);
    import indexer_pkg::*;
    // Words are staged well ahead of the start request and then held.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_words <= '0;
        end else if (load) begin
            link_words <= next_words;
        end
    end
endmodule
`default_nettype wire

// ---- indexer_station_positioning_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module indexer_station_positioning_test;
    import indexer_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ld;
    logic awready, wready, bvalid, arready, rvalid, tc, inpos, warn;
    logic [7:0] awaddr, araddr, tgt;
    logic [31:0] wdata, rdata, lim, dly, em;
    logic [1:0] bresp, rresp, eb;
    logic [15:0] torque, tsel, t1, t2;
    logic [3:0] strb;
    logic [33:0] er;
    link_words_type nw, lw;
    int failures, checks, cyc, cnt, low_cnt;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [31:0] mq[$];

    indexer_station_positioning i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_words(lw),
        .travel_complete_flag(tc), .in_position_flag(inpos),
        .homing_incomplete_warning(warn), .torque_limit(torque),
        .table_select(tsel), .target_station(tgt));
    link_master_model i_link (.aclk(aclk), .aresetn(aresetn), .load(ld),
        .next_words(nw), .link_words(lw));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Compares every bus answer with the oldest note; counts travel cycles.
    always @(posedge aclk) begin
        cyc++;
        if (!tc) low_cnt++;
        if (bvalid && bready) begin
            eb = bq.pop_front();
            `CHK("bresp", eb, bresp)
        end
        if (rvalid && rready) begin
            er = rq.pop_front();
            em = mq.pop_front();
            `CHK("rdata", er[31:0], rdata & em)
            `CHK("rresp", er[33:32], rresp)
        end
        if (cyc == 5000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        bq.push_back(e);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) bready <= 1'b0;
        end while (awvalid || wvalid || bready);
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e,
                      input logic [31:0] m);
        rq.push_back(e);
        mq.push_back(m);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) rready <= 1'b0;
        end while (arvalid || rready);
    endtask

    // Clears then raises the start bit so that it shows a rising edge.
    task automatic go(input logic [31:0] c);
        wr(ctrl_offset, c, resp_okay);
        // Mode hold time before start, cut short: the model has no link delay.
        repeat (4) @(posedge aclk);
        low_cnt = 0;
        wr(ctrl_offset, c | 32'h0000_0001, resp_okay);
    endtask

    task automatic put(input link_words_type w);
        nw <= w;
        ld <= 1'b1;
        @(posedge aclk);
        ld <= 1'b0;
    endtask

    // Waits until travel and hold are over, a bounded number of cycles.
    task automatic wait_idle();
        cnt = 0;
        while (!(tc && !inpos) && cnt < 500) begin
            @(posedge aclk);
            cnt++;
        end
        `CHK("idle reached", 1'b1, cnt < 500)
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, ld} = '0;
        {awaddr, araddr, wdata, nw} = '0;
        strb = 4'hF;
        void'($urandom(21));
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(ctrl_offset, {resp_okay, ctrl_reset}, 32'hFFFF_FFFF);
        rd(param_offset, {resp_okay, param_reset}, 32'hFFFF_FFFF);
        rd(limit_offset, {resp_okay, limit_reset}, 32'hFFFF_FFFF);
        rd(delay_offset, {resp_okay, delay_reset}, 32'hFFFF_FFFF);
        strb <= 4'hC;
        wr(param_offset, 32'hFFFF_FFFF, resp_okay);
        strb <= 4'hF;
        rd(param_offset, {resp_okay, 16'hFFFF, param_reset[15:0]},
           32'hFFFF_FFFF);
        rd(8'h18, {resp_slverr, 32'h0000_0000}, 32'hFFFF_FFFF);
        wr(status_offset, 32'h0000_0001, resp_slverr);
        t1 = 16'($urandom);
        t2 = 16'($urandom);
        lim = {16'($urandom), 16'($urandom)};
        dly = {16'($urandom), 16'h0006};
        wr(param_offset, 32'h0000_0808, resp_okay);
        wr(limit_offset, lim, resp_okay);
        wr(delay_offset, dly, resp_okay);
        put('{16'h0007, t1, 16'h0002, t2});
        go(32'h0000_002C);
        `CHK("wrong mode", 1'b1, tc)
        go(32'h0000_0008);
        `CHK("unhomed warn", 1'b1, warn)
        `CHK("unhomed idle", 1'b1, tc)
        go(32'h0000_002A);
        `CHK("moving", 1'b0, tc)
        `CHK("run torque", lim[15:0], torque)
        `CHK("warn cleared", 1'b0, warn)
        put('{16'h0001, t2, 16'h0002, t1});
        wr(ctrl_offset, 32'h0000_002A, resp_okay);
        wr(ctrl_offset, 32'h0000_002B, resp_okay);
        cnt = 0;
        while (!inpos && cnt < 500) begin
            @(posedge aclk);
            cnt++;
        end
        `CHK("in position", 1'b1, inpos)
        cnt = 0;
        while (torque !== dly[31:16] && cnt < 500) begin
            @(posedge aclk);
            cnt++;
        end
        `CHK("stop delay", 1'b1, cnt >= 5 && cnt <= 7)
        wait_idle();
        rd(position_offset, {resp_okay, 32'h0700_0007}, 32'hFF00_00FF);
        `CHK("target", 8'h07, tgt)
        `CHK("table", t1, tsel)
        put('{16'h0005, t2, 16'h0001, t1});
        go(32'h0000_0028);
        `CHK("rev torque", lim[31:16], torque)
        wait_idle();
        `CHK("short way", 1'b1, low_cnt < 16)
        `CHK("table", t2, tsel)
        put('{16'h0002, t2, 16'h0006, t1});
        wr(param_offset, 32'h0001_0808, resp_okay);
        go(32'h0000_0038);
        `CHK("assign torque", lim[15:0], torque)
        wait_idle();
        `CHK("wrap way", 1'b1, low_cnt >= 28)
        `CHK("next station", 8'h06, tgt)
        `CHK("low word table", t1, tsel)
        rd(position_offset, {resp_okay, 32'h0600_0006}, 32'hFF00_00FF);
        wr(ctrl_offset, 32'h0000_0068, resp_okay);
        @(posedge aclk);
        `CHK("settled", 1'b1, inpos)
        give_verdict();
    end
endmodule
`default_nettype wire
